// ---- verilog/pfg_pkg.sv ----
/*
 * Shared constants and types for the port F/G alternate-function override block.
 * Assumes one 250 MHz system clock and an APB master with 32-bit data.
 */
package pfg_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PF_PORT = 8'h04;
    localparam logic [7:0] ADDR_PF_DIR = 8'h08;
    localparam logic [7:0] ADDR_PG_PORT = 8'h0C;
    localparam logic [7:0] ADDR_PG_DIR = 8'h10;
    localparam logic [7:0] ADDR_PF_IN = 8'h14;
    localparam logic [7:0] ADDR_PG_IN = 8'h18;
    localparam logic [7:0] ADDR_TAP_STAT = 8'h1C;
    localparam logic [7:0] ADDR_TAP_CAP = 8'h20;
    localparam logic [7:0] ADDR_TAP_UPD = 8'h24;
    // Control register fields
    localparam int CTRL_TEST_EN_BIT = 0;
    localparam int CTRL_LCD_EN_BIT = 1;
    localparam int CTRL_PUD_BIT = 2;
    localparam int CTRL_MASK_LSB = 4;
    localparam int MASK_W = 4;
    localparam logic [7:0] CTRL_RST = 8'h01;
    // Pin positions
    localparam int PF_TCK = 4;
    localparam int PF_TMS = 5;
    localparam int PF_TDO = 6;
    localparam int PF_TDI = 7;
    localparam int PG_LCD_SEGMENT_4 = 2;
    localparam int PG_T1 = 3;
    localparam int PG_T0 = 4;
    localparam int PG_RESET = 5;
    // LCD port mask thresholds (strictly greater than)
    localparam logic [3:0] MASK_LCD_SEGMENT_23_MIN = 4'h5;
    localparam logic [3:0] MASK_LCD_SEGMENT_24_MIN = 4'h6;
    localparam logic [3:0] MASK_LCD_SEGMENT_13_MIN = 4'h0;
    // Pin output reset values (test port enabled out of reset)
    localparam logic [7:0] PF_PU_RST = 8'hB0;
    localparam logic [7:0] PF_IE_RST = 8'h10;
    localparam logic [5:0] PG_PU_RST = 6'h20;
    localparam logic [5:0] PG_IE_RST = 6'h3F;
    // TAP
    localparam int IR_W = 4;
    localparam int DR_W = 8;
    localparam logic [3:0] IR_BYPASS = 4'hF;
    localparam logic [3:0] IR_CAPTURE = 4'h1;

    typedef struct packed {
        logic pu_en;
        logic pu_val;
        logic dd_en;
        logic dd_val;
        logic pv_en;
        logic pv_val;
        logic ie_en;
        logic ie_val;
    } pfg_ovr_t;

    typedef struct packed {
        logic pu;
        logic oe;
        logic out;
        logic ie;
    } pfg_pin_t;

    typedef enum logic [3:0] {
        ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_DSHIFT, ST_EX1_DR, ST_PA_DR,
        ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_ISHIFT, ST_EX1_IR,
        ST_PA_IR, ST_EX2_IR, ST_UPD_IR
    } pfg_tap_t;
endpackage

// ---- verilog/pfg_override.sv ----
/*
 * Port F/G pin override logic with a small test access port and APB registers.
 * Assumes an APB master on i_clock; pins arrive asynchronous and are synchronised.
 */
// Register access over APB and the register offsets were chosen for this implementation.
// Behaviour
// [RULE1] Each port F pin feeds the converter channel of the same index.
// [RULE2] Software keeps port F outputs quiet during a conversion.
// [RULE3] Test port enabled keeps TDI, TMS, TCK pull-ups on, also in reset.
// [RULE4] Test port enabled takes the four test pins away from GPIO.
// [RULE5] Test pins pulled up and inputs; TDO output only while shifting.
// [RULE6] TDO drives shifted data in shift states, else pulled high.
// [RULE7] TDI shifts into instruction or selected data chain.
// [RULE8] TMS steers the TAP; all TAP action follows TCK edges.
// [RULE9] Test port enabled: TCK input enabled, TDI, TMS, TDO inputs disabled.
// [RULE10] Port F bits 3..0 get no overrides.
// [RULE11] Port G bit 5 input only, pull-up on; reset unless fuse is zero.
// [RULE12] LCD on and mask above 5: bit 4 output, no pull-up, no input.
// [RULE13] LCD on: bits 3..0 pull-up off, input, input disabled per mask.
// [RULE14] Port G bit 4 feeds timer 0 count, bit 3 feeds timer 1.
// [RULE15] Override value replaces register value while override enable is high.
`timescale 1ns/1ns
module pfg_override import pfg_pkg::*; #(
    parameter int PF_W = 8,
    parameter int PG_W = 6
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [PF_W-1:0] i_pf_pin,
    input wire logic [PG_W-1:0] i_pg_pin,
    input wire logic i_reset_pin_disable_fuse,
    output logic [PF_W-1:0] o_pf_pullup,
    output logic [PF_W-1:0] o_pf_oe,
    output logic [PF_W-1:0] o_pf_out,
    output logic [PF_W-1:0] o_pf_ie,
    output logic [PG_W-1:0] o_pg_pullup,
    output logic [PG_W-1:0] o_pg_oe,
    output logic [PG_W-1:0] o_pg_out,
    output logic [PG_W-1:0] o_pg_ie,
    output logic [PF_W-1:0] o_analog_io_path,
    output logic o_timer0_ext_count_in,
    output logic o_timer1_ext_count_in,
    output logic o_ext_reset_n
);
    localparam int SW = PF_W + PG_W + 1;
    // Pins with pull-ups idle high, so release shows no false TCK edge
    localparam logic [SW-1:0] SYNC_RST = SW'({1'b1, PG_PU_RST, PF_PU_RST});

    // Override resolution for one pin
    function automatic pfg_pin_t pin_resolve(pfg_ovr_t ov, logic port, logic dir,
                                             logic pud);
        pfg_pin_t p;
        p.pu = ov.pu_en ? ov.pu_val : (port & ~dir & ~pud); // [RULE15]
        p.oe = ov.dd_en ? ov.dd_val : dir;
        p.out = ov.pv_en ? ov.pv_val : port;
        p.ie = ov.ie_en ? ov.ie_val : 1'b1;
        return p;
    endfunction

    logic [SW-1:0] s1_q, s2_q, s3_q;
    logic [7:0] ctrl_q, ctrl_d;
    logic [PF_W-1:0] pf_port_q, pf_port_d, pf_dir_q, pf_dir_d;
    logic [PG_W-1:0] pg_port_q, pg_port_d, pg_dir_q, pg_dir_d;
    logic [DR_W-1:0] cap_q, cap_d, upd_q, upd_d, dr_sh_q, dr_sh_d;
    logic [IR_W-1:0] ir_q, ir_d, ir_sh_q, ir_sh_d;
    logic [31:0] prdata_q, prdata_d;
    logic err_q, err_d;
    pfg_tap_t st_q, st_d, st_nxt;
    logic tdo_q, tdo_d;
    logic [PF_W-1:0] pf_pu_q, pf_oe_q, pf_out_q, pf_ie_q;
    logic [PF_W-1:0] pf_pu_d, pf_oe_d, pf_out_d, pf_ie_d;
    logic [PG_W-1:0] pg_pu_q, pg_oe_q, pg_out_q, pg_ie_q;
    logic [PG_W-1:0] pg_pu_d, pg_oe_d, pg_out_d, pg_ie_d;
    logic t0_q, t0_d, t1_q, t1_d, rstn_q, rstn_d;
    logic test_port_enable, lcd_enable, pud;
    logic [MASK_W-1:0] lcd_port_mask;
    logic tap_instr_shift_state, tap_data_shift_state, shifting, bypass;
    logic tck_rise, tck_fall, tms, tdi, fuse_s;
    logic [PF_W-1:0] pf_s;
    logic [PG_W-1:0] pg_s;

    assign test_port_enable = ctrl_q[CTRL_TEST_EN_BIT];
    assign lcd_enable = ctrl_q[CTRL_LCD_EN_BIT];
    assign pud = ctrl_q[CTRL_PUD_BIT];
    assign lcd_port_mask = ctrl_q[CTRL_MASK_LSB +: MASK_W];
    assign pf_s = s2_q[PF_W-1:0];
    assign pg_s = s2_q[PF_W +: PG_W];
    assign fuse_s = s2_q[SW-1];
    assign tms = pf_s[PF_TMS];
    assign tdi = pf_s[PF_TDI];
    // Edges seen only after the second stage; the first stage feeds nothing else
    assign tck_rise = s2_q[PF_TCK] & ~s3_q[PF_TCK]; // [RULE8]
    assign tck_fall = ~s2_q[PF_TCK] & s3_q[PF_TCK];
    assign tap_instr_shift_state = (st_q == ST_ISHIFT);
    assign tap_data_shift_state = (st_q == ST_DSHIFT);
    assign shifting = tap_instr_shift_state | tap_data_shift_state;
    assign bypass = (ir_q == IR_BYPASS);

    // Pin synchronisers; stage three is edge history for TCK
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            s1_q <= SYNC_RST;
            s2_q <= SYNC_RST;
            s3_q <= SYNC_RST;
        end else begin
            s1_q <= {i_reset_pin_disable_fuse, i_pg_pin, i_pf_pin};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Converter channels follow their pins one for one
    assign o_analog_io_path = pf_s; // [RULE1]

    // APB: decode and read data latched in setup, zero wait states
    always_comb begin
        ctrl_d = ctrl_q;
        pf_port_d = pf_port_q;
        pf_dir_d = pf_dir_q;
        pg_port_d = pg_port_q;
        pg_dir_d = pg_dir_q;
        cap_d = cap_q;
        prdata_d = prdata_q;
        err_d = err_q;
        if (i_psel && !i_penable) begin
            err_d = 1'b0;
            prdata_d = '0;
            case (i_paddr)
                ADDR_CTRL: prdata_d[7:0] = ctrl_q;
                ADDR_PF_PORT: prdata_d[PF_W-1:0] = pf_port_q;
                ADDR_PF_DIR: prdata_d[PF_W-1:0] = pf_dir_q;
                ADDR_PG_PORT: prdata_d[PG_W-1:0] = pg_port_q;
                ADDR_PG_DIR: prdata_d[PG_W-1:0] = pg_dir_q;
                ADDR_PF_IN: prdata_d[PF_W-1:0] = pf_s & pf_ie_q;
                ADDR_PG_IN: prdata_d[PG_W-1:0] = pg_s & pg_ie_q;
                ADDR_TAP_STAT: prdata_d[7:0] = {ir_q, st_q};
                ADDR_TAP_CAP: prdata_d[DR_W-1:0] = cap_q;
                ADDR_TAP_UPD: prdata_d[DR_W-1:0] = upd_q;
                default: err_d = 1'b1;
            endcase
            if (i_pwrite) begin
                prdata_d = '0;
            end
        end
        if (i_psel && i_penable && i_pwrite && !err_q) begin
            case (i_paddr)
                ADDR_CTRL: ctrl_d = i_pwdata[7:0];
                ADDR_PF_PORT: pf_port_d = i_pwdata[PF_W-1:0];
                ADDR_PF_DIR: pf_dir_d = i_pwdata[PF_W-1:0];
                ADDR_PG_PORT: pg_port_d = i_pwdata[PG_W-1:0];
                ADDR_PG_DIR: pg_dir_d = i_pwdata[PG_W-1:0];
                ADDR_TAP_CAP: cap_d = i_pwdata[DR_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_q <= CTRL_RST;
            pf_port_q <= '0;
            pf_dir_q <= '0;
            pg_port_q <= '0;
            pg_dir_q <= '0;
            cap_q <= '0;
            prdata_q <= '0;
            err_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            pf_port_q <= pf_port_d;
            pf_dir_q <= pf_dir_d;
            pg_port_q <= pg_port_d;
            pg_dir_q <= pg_dir_d;
            cap_q <= cap_d;
            prdata_q <= prdata_d;
            err_q <= err_d;
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = 1'b1;
    assign o_pslverr = err_q;

    // TAP next state, steered by TMS
    always_comb begin
        unique case (st_q)
            ST_TLR: st_nxt = tms ? ST_TLR : ST_RTI;
            ST_RTI: st_nxt = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: st_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: st_nxt = tms ? ST_EX1_DR : ST_DSHIFT;
            ST_DSHIFT: st_nxt = tms ? ST_EX1_DR : ST_DSHIFT;
            ST_EX1_DR: st_nxt = tms ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR: st_nxt = tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: st_nxt = tms ? ST_UPD_DR : ST_DSHIFT;
            ST_UPD_DR: st_nxt = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: st_nxt = tms ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: st_nxt = tms ? ST_EX1_IR : ST_ISHIFT;
            ST_ISHIFT: st_nxt = tms ? ST_EX1_IR : ST_ISHIFT;
            ST_EX1_IR: st_nxt = tms ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR: st_nxt = tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: st_nxt = tms ? ST_UPD_IR : ST_ISHIFT;
            ST_UPD_IR: st_nxt = tms ? ST_SEL_DR : ST_RTI;
        endcase
    end

    // TAP actions on TCK edges; held in reset while the port is off
    always_comb begin
        st_d = st_q;
        ir_d = ir_q;
        ir_sh_d = ir_sh_q;
        dr_sh_d = dr_sh_q;
        upd_d = upd_q;
        tdo_d = tdo_q;
        if (!test_port_enable) begin
            st_d = ST_TLR;
            ir_d = IR_BYPASS;
        end else if (tck_rise) begin
            st_d = st_nxt; // [RULE8]
            if (st_q == ST_TLR) begin
                ir_d = IR_BYPASS;
            end
            if (st_q == ST_CAP_IR) begin
                ir_sh_d = IR_CAPTURE;
            end
            if (tap_instr_shift_state) begin
                ir_sh_d = {tdi, ir_sh_q[IR_W-1:1]}; // [RULE7]
            end
            if (st_q == ST_UPD_IR) begin
                ir_d = ir_sh_q;
            end
            if (st_q == ST_CAP_DR) begin
                dr_sh_d = bypass ? '0 : cap_q;
            end
            if (tap_data_shift_state) begin
                if (bypass) begin
                    dr_sh_d[0] = tdi; // [RULE7]
                end else begin
                    dr_sh_d = {tdi, dr_sh_q[DR_W-1:1]}; // [RULE7]
                end
            end
            if (st_q == ST_UPD_DR && !bypass) begin
                upd_d = dr_sh_q;
            end
        end else if (tck_fall) begin
            // TDO changes on the falling edge so the tester samples it stable
            tdo_d = tap_instr_shift_state ? ir_sh_q[0] : dr_sh_q[0];
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            st_q <= ST_TLR;
            ir_q <= IR_BYPASS;
            ir_sh_q <= '0;
            dr_sh_q <= '0;
            upd_q <= '0;
            tdo_q <= 1'b1;
        end else begin
            st_q <= st_d;
            ir_q <= ir_d;
            ir_sh_q <= ir_sh_d;
            dr_sh_q <= dr_sh_d;
            upd_q <= upd_d;
            tdo_q <= tdo_d;
        end
    end

    // Pin override tables and resolution
    always_comb begin
        pfg_ovr_t ov;
        pfg_pin_t p;
        ov = '0;
        p = '0;
        for (int i = 0; i < PF_W; i++) begin
            ov = '0; // [RULE10]
            if (i >= PF_TCK) begin
                ov.pu_en = test_port_enable; // [RULE3]
                ov.pu_val = 1'b1; // [RULE5]
                ov.dd_en = test_port_enable; // [RULE4]
                ov.dd_val = (i == PF_TDO) ? shifting : 1'b0; // [RULE5]
                ov.pv_en = (i == PF_TDO) & test_port_enable; // [RULE6]
                ov.pv_val = tdo_q;
                ov.ie_en = test_port_enable; // [RULE9]
                ov.ie_val = (i == PF_TCK);
            end
            p = pin_resolve(ov, pf_port_q[i], pf_dir_q[i], pud);
            pf_pu_d[i] = p.pu;
            pf_oe_d[i] = p.oe;
            pf_out_d[i] = p.out;
            pf_ie_d[i] = p.ie;
        end
        for (int i = 0; i < PG_W; i++) begin
            ov = '0;
            if (i == PG_RESET) begin
                ov.pu_en = 1'b1; // [RULE11]
                ov.pu_val = 1'b1;
                ov.dd_en = 1'b1;
            end else if (i == PG_T0) begin
                ov.dd_en = lcd_enable && (lcd_port_mask > MASK_LCD_SEGMENT_23_MIN); // [RULE12]
                ov.dd_val = 1'b1;
            end else if (i == PG_T1) begin
                ov.dd_en = lcd_enable && (lcd_port_mask > MASK_LCD_SEGMENT_24_MIN); // [RULE13]
            end else if (i == PG_LCD_SEGMENT_4) begin
                ov.dd_en = lcd_enable; // [RULE13]
            end else begin
                ov.dd_en = lcd_enable && (lcd_port_mask > MASK_LCD_SEGMENT_13_MIN); // [RULE13]
            end
            if (i != PG_RESET) begin
                ov.pu_en = ov.dd_en;
                ov.ie_en = ov.dd_en;
            end
            p = pin_resolve(ov, pg_port_q[i], pg_dir_q[i], pud);
            pg_pu_d[i] = p.pu;
            pg_oe_d[i] = p.oe;
            pg_out_d[i] = p.out;
            pg_ie_d[i] = p.ie;
        end
        t0_d = pg_s[PG_T0] & pg_ie_d[PG_T0]; // [RULE14]
        t1_d = pg_s[PG_T1] & pg_ie_d[PG_T1]; // [RULE14]
        // Fuse at zero turns the reset pin into a plain input
        rstn_d = fuse_s ? pg_s[PG_RESET] : 1'b1; // [RULE11]
    end

    // Reset values keep the test pull-ups on while reset is held
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            pf_pu_q <= PF_PU_RST; // [RULE3]
            pf_oe_q <= '0;
            pf_out_q <= '0;
            pf_ie_q <= PF_IE_RST;
            pg_pu_q <= PG_PU_RST;
            pg_oe_q <= '0;
            pg_out_q <= '0;
            pg_ie_q <= PG_IE_RST;
            t0_q <= 1'b0;
            t1_q <= 1'b0;
            rstn_q <= 1'b1;
        end else begin
            pf_pu_q <= pf_pu_d;
            pf_oe_q <= pf_oe_d;
            pf_out_q <= pf_out_d;
            pf_ie_q <= pf_ie_d;
            pg_pu_q <= pg_pu_d;
            pg_oe_q <= pg_oe_d;
            pg_out_q <= pg_out_d;
            pg_ie_q <= pg_ie_d;
            t0_q <= t0_d;
            t1_q <= t1_d;
            rstn_q <= rstn_d;
        end
    end

    assign o_pf_pullup = pf_pu_q;
    assign o_pf_oe = pf_oe_q;
    assign o_pf_out = pf_out_q;
    assign o_pf_ie = pf_ie_q;
    assign o_pg_pullup = pg_pu_q;
    assign o_pg_oe = pg_oe_q;
    assign o_pg_out = pg_out_q;
    assign o_pg_ie = pg_ie_q;
    assign o_timer0_ext_count_in = t0_q;
    assign o_timer1_ext_count_in = t1_q;
    assign o_ext_reset_n = rstn_q;

    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    sequence s_leave_tlr;
        test_port_enable && tck_rise && st_q == ST_TLR && !tms;
    endsequence
    property p_adc_route;
        i_resetn |-> ##2 o_analog_io_path == $past(i_pf_pin, 2);
    endproperty
    a_adc_route: assert property (p_adc_route) else $error("adc route"); // [RULE1]
    property p_tap_pullups;
        test_port_enable |=> (o_pf_pullup & PF_PU_RST) == PF_PU_RST;
    endproperty
    a_tap_pullups: assert property (p_tap_pullups) else $error("tap pullups"); // [RULE3]
    property p_tap_gpio;
        $past(test_port_enable) |-> !o_pf_oe[PF_TDI] && !o_pf_oe[PF_TMS] && !o_pf_oe[PF_TCK];
    endproperty
    a_tap_gpio: assert property (p_tap_gpio) else $error("tap pins as gpio"); // [RULE4]
    property p_tdo_dir;
        $past(test_port_enable) |-> o_pf_oe[PF_TDO] == $past(shifting);
    endproperty
    a_tdo_dir: assert property (p_tdo_dir) else $error("tdo direction"); // [RULE5]
    property p_tdo_val;
        $past(test_port_enable && shifting) |-> o_pf_out[PF_TDO] == $past(tdo_q);
    endproperty
    a_tdo_val: assert property (p_tdo_val) else $error("tdo value"); // [RULE6]
    property p_ishift;
        test_port_enable && tck_rise && tap_instr_shift_state |=> ir_sh_q[IR_W-1] == $past(tdi);
    endproperty
    a_ishift: assert property (p_ishift) else $error("tdi not shifted"); // [RULE7]
    property p_tms_steer;
        s_leave_tlr |=> st_q == ST_RTI;
    endproperty
    a_tms_steer: assert property (p_tms_steer) else $error("tap step"); // [RULE8]
    property p_tap_hold;
        test_port_enable && !tck_rise |=> $stable(st_q);
    endproperty
    a_tap_hold: assert property (p_tap_hold) else $error("tap moved without tck"); // [RULE8]
    property p_test_ie;
        $past(test_port_enable) |-> o_pf_ie[PF_TDI:PF_TCK] == 4'h1;
    endproperty
    a_test_ie: assert property (p_test_ie) else $error("test input enables"); // [RULE9]
    property p_low_free;
        i_resetn |=> o_pf_oe[3:0] == $past(pf_dir_q[3:0]) && o_pf_ie[3:0] == 4'hF;
    endproperty
    a_low_free: assert property (p_low_free) else $error("low port f overridden"); // [RULE10]
    property p_reset_pin;
        o_pg_pullup[PG_RESET] && !o_pg_oe[PG_RESET];
    endproperty
    a_reset_pin: assert property (p_reset_pin) else $error("reset pin"); // [RULE11]
    property p_lcd_segment_23;
        $past(lcd_enable && lcd_port_mask > MASK_LCD_SEGMENT_23_MIN)
            |-> o_pg_oe[PG_T0] && !o_pg_pullup[PG_T0] && !o_timer0_ext_count_in;
    endproperty
    a_lcd_segment_23: assert property (p_lcd_segment_23) else $error("segment 23 pin"); // [RULE12]
    property p_lcd_segment_4;
        $past(lcd_enable) |-> !o_pg_oe[PG_LCD_SEGMENT_4] && !o_pg_ie[PG_LCD_SEGMENT_4];
    endproperty
    a_lcd_segment_4: assert property (p_lcd_segment_4) else $error("segment 4 pin"); // [RULE13]
    property p_timer1;
        $past(!lcd_enable) |-> o_timer1_ext_count_in == $past(pg_s[PG_T1]);
    endproperty
    a_timer1: assert property (p_timer1) else $error("timer 1 source"); // [RULE14]
    property p_no_ovr;
        $past(!test_port_enable) |-> o_pf_out == $past(pf_port_q);
    endproperty
    a_no_ovr: assert property (p_no_ovr) else $error("register value lost"); // [RULE15]
endmodule // pfg_override

// ---- verification/pfg_pin_model.sv ----
/* Board side of ports F and G: tester pins, LCD/timer sources, pull-up resolution.
   Assumes the bench sets external drive through set_ext and tck. */
`timescale 1ns/1ns
module pfg_pin_model import pfg_pkg::*; (
    input wire logic i_clock,
    input wire logic [7:0] i_pf_oe,
    input wire logic [7:0] i_pf_out,
    input wire logic [7:0] i_pf_pullup,
    input wire logic [5:0] i_pg_oe,
    input wire logic [5:0] i_pg_out,
    input wire logic [5:0] i_pg_pullup,
    output logic [7:0] o_pf_pin,
    output logic [5:0] o_pg_pin
);
    logic [7:0] pf_lvl = 8'h00;
    logic [7:0] pf_drv = 8'h00;
    logic [5:0] pg_lvl = 6'h3F;
    logic [5:0] pg_drv = 6'h3F;
    logic float_q = 1'b0;
    // Floating pin wanders, so a stale value never looks valid
    always @(posedge i_clock) begin
        float_q <= ~float_q;
    end
    // Wire level: device driver, else tester, else pull-up or noise
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            o_pf_pin[b] = i_pf_oe[b] ? i_pf_out[b] : pf_drv[b] ? pf_lvl[b] : i_pf_pullup[b] | float_q;
        end
        for (int b = 0; b < 6; b++) begin
            o_pg_pin[b] = i_pg_oe[b] ? i_pg_out[b] : pg_drv[b] ? pg_lvl[b] : i_pg_pullup[b] | float_q;
        end
    end
    task automatic set_ext(input logic [7:0] fl, fd, input logic [5:0] gl, gd);
        pf_lvl <= fl;
        pf_drv <= fd;
        pg_lvl <= gl;
        pg_drv <= gd;
    endtask
    // One tester clock, TCK idles low; phases of 3 system clocks
    task automatic tck(input logic tms, input logic tdi);
        pf_lvl[PF_TMS] <= tms;
        pf_lvl[PF_TDI] <= tdi;
        repeat (3) @(posedge i_clock);
        pf_lvl[PF_TCK] <= 1'b1;
        repeat (3) @(posedge i_clock);
        pf_lvl[PF_TCK] <= 1'b0;
        repeat (3) @(posedge i_clock);
    endtask
endmodule // pfg_pin_model

// ---- verification/port_f_g_alt_function_override_tb.sv ----
/* Self-checking bench for the port F/G override block over APB.
   Assumes the pin model in pfg_pin_model.sv and an APB slave that raises pready. */
`timescale 1ns/1ns
module port_f_g_alt_function_override_tb;
    import pfg_pkg::*;
    logic i_clock = 1'b0;
    logic i_resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic fuse = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, t0, t1, rstn_o, b4, b3, b0;
    logic [7:0] pf_pin, pf_pu, pf_oe, pf_out, pf_ie, an;
    logic [5:0] pg_pin, pg_pu, pg_oe, pg_out, pg_ie;
    logic [4:0] ov;
    int miscompares = 0;
    int checks_done = 0;
    always #2 i_clock = ~i_clock;
    pfg_override uut (.i_clock(i_clock), .i_resetn(i_resetn), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_pf_pin(pf_pin),
        .i_pg_pin(pg_pin), .i_reset_pin_disable_fuse(fuse), .o_pf_pullup(pf_pu),
        .o_pf_oe(pf_oe), .o_pf_out(pf_out), .o_pf_ie(pf_ie), .o_pg_pullup(pg_pu),
        .o_pg_oe(pg_oe), .o_pg_out(pg_out), .o_pg_ie(pg_ie), .o_analog_io_path(an),
        .o_timer0_ext_count_in(t0), .o_timer1_ext_count_in(t1), .o_ext_reset_n(rstn_o));
    pfg_pin_model pm (.i_clock(i_clock), .i_pf_oe(pf_oe), .i_pf_out(pf_out),
        .i_pf_pullup(pf_pu), .i_pg_oe(pg_oe), .i_pg_out(pg_out), .i_pg_pullup(pg_pu),
        .o_pf_pin(pf_pin), .o_pg_pin(pg_pin));
    // APB transfer; waits for pready, takes data at that edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge i_clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (6) @(posedge i_clock);
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Watchdog far beyond the expected run
    initial begin
        #200000;
        miscompares++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge i_clock);
        chk(pf_pu, 8'hB0);
        chk(pg_pu, 6'h20);
        i_resetn <= 1'b1;
        apb(0, ADDR_CTRL, 0);
        chk(rd, 32'h1);
        chk(pready, 1'b1);
        apb(0, 8'hFC, 0);
        chk(err, 1'b1);
        apb(1, ADDR_PF_DIR, 32'hFF);
        apb(1, ADDR_PF_PORT, 32'hFF);
        pm.set_ext(8'h00, 8'hB0, 6'h3F, 6'h3F);
        settle();
        chk(pf_oe, 8'h0F);
        chk(pf_pu, 8'hF0);
        chk(pf_ie, 8'h1F);
        // Walk to data shift, then pass bits through bypass
        pm.tck(0, 0);
        pm.tck(1, 0);
        pm.tck(0, 0);
        pm.tck(0, 0);
        settle();
        chk(pf_oe[PF_TDO], 1'b1);
        apb(0, ADDR_TAP_STAT, 0);
        chk(rd[3:0], ST_DSHIFT);
        pm.tck(0, 1);
        settle();
        chk(pf_out[PF_TDO], 1'b1);
        pm.tck(0, 0);
        settle();
        chk(pf_out[PF_TDO], 1'b0);
        pm.tck(1, 0);
        settle();
        chk(pf_oe[PF_TDO], 1'b0);
        // Over to the instruction chain: capture shows 0001, then load A
        for (int k = 0; k < 3; k++) begin
            pm.tck(1, 0);
        end
        pm.tck(0, 0);
        pm.tck(0, 0);
        settle();
        chk(pf_out[PF_TDO], 1'b1);
        pm.tck(0, 0);
        pm.tck(0, 1);
        pm.tck(0, 0);
        pm.tck(1, 1);
        pm.tck(1, 0);
        pm.tck(0, 0);
        apb(0, ADDR_TAP_STAT, 0);
        chk(rd[7:0], 8'hA1);
        // Test port off hands all pins back
        apb(1, ADDR_CTRL, 0);
        settle();
        chk(pf_oe, 8'hFF);
        // Port F all inputs, so no output switches while channels are sampled
        apb(1, ADDR_PF_DIR, 0);
        pm.set_ext(8'hA5, 8'hFF, 6'h3F, 6'h3F);
        settle();
        chk(an, 8'hA5);
        // LCD masks at every threshold
        apb(1, ADDR_PG_DIR, 0);
        apb(1, ADDR_PG_PORT, 32'h1F);
        for (int m = 0; m < 8; m++) begin
            apb(1, ADDR_CTRL, {24'h0, m[3:0], 4'h2});
            settle();
            b4 = (m > 5);
            b3 = (m > 6);
            b0 = (m > 0);
            ov = {b4, b3, 1'b1, b0, b0};
            chk(pg_pu, {1'b1, ~ov});
            chk(pg_oe, {1'b0, b4, 4'h0});
            chk(pg_ie, {1'b1, ~ov});
            chk(pg_out, 6'h1F);
            chk({t0, t1}, {~b4, ~b3});
        end
        pm.set_ext(8'hA5, 8'hFF, 6'h1F, 6'h3F);
        settle();
        chk(rstn_o, 1'b0);
        fuse <= 1'b0;
        settle();
        chk(rstn_o, 1'b1);
        report_and_stop();
    end
endmodule // port_f_g_alt_function_override_tb
